// ---- rtl/e1_map_common_pkg.sv ----
package e1_map_common_pkg;
  // Register offsets on the microprocessor bus.
  localparam logic [7:0] ADDR_PROV  = 8'h14;
  localparam logic [7:0] ADDR_CLEAR = 8'h15;
  localparam logic [7:0] ADDR_V4    = 8'hF1;
  localparam logic [7:0] ADDR_BIP2  = 8'hF5;
  // Field positions in the provisioning register.
  localparam int UEAL_BIT  = 4;
  localparam int AISSEL_BIT = 3;
  localparam int RDISEL_BIT = 2;
  localparam int A2L_BIT   = 1;
  localparam int HWIE_BIT  = 0;
  // Field positions in the command register.
  localparam int GCLR_BIT  = 7;
  localparam int ACLR_BIT  = 6;
  localparam int BCLR_BIT  = 5;
  localparam int PRST_BIT  = 4;
  localparam int RINI_BIT  = 0;
  // Field positions in the V4 and BIP-2 registers.
  localparam int V4EN_BIT  = 3;
  localparam int B2DIS_BIT = 7;
  // Writable bit masks; unused positions always read as zero.
  localparam logic [7:0] MASK_PROV  = 8'h1F;
  localparam logic [7:0] MASK_CLEAR = 8'hF1;
  localparam logic [7:0] MASK_V4    = 8'h08;
  localparam logic [7:0] MASK_BIP2  = 8'h80;
  // Reset values.
  localparam logic [7:0] RST_REG = 8'h00;
  // RDI persistence counts.
  localparam logic [3:0] RDI_LONG  = 4'hA;
  localparam logic [3:0] RDI_SHORT = 4'h5;
  // Lengths of the self-clearing cycles, in clock cycles.
  localparam int CYC_GCLR = 16;
  localparam int CYC_ACLR = 4;
  localparam int CYC_PRST = 8;
  localparam int CYC_RINI = 256;
  // Bus modes.
  localparam logic [1:0] MODE_MUX  = 2'h0;
  localparam logic [1:0] MODE_URING = 2'h1;
  localparam logic [1:0] MODE_BRING = 2'h2;
endpackage

// ---- rtl/e1_mapper_common_provisioning.sv ----
module e1_mapper_common_provisioning
  import e1_map_common_pkg::*;
#(
  parameter int GCLR_CYCLES = CYC_GCLR,
  parameter int ACLR_CYCLES = CYC_ACLR,
  parameter int PRST_CYCLES = CYC_PRST,
  parameter int RINI_CYCLES = CYC_RINI
) (
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       resetn,
  // Microprocessor register port, one-cycle strobes.
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdData,
  // Mapper context from the datapath.
  input  wire logic [1:0] busMode,
  input  wire logic       dropFromA,
  input  wire logic       activeBusB,
  input  wire logic       au3Framing,
  input  wire logic       irqCondition,
  // Derived controls towards the four ports.
  output logic            unequippedOnA,
  output logic            unequippedOnB,
  output logic            ptrAisDetectEn,
  output logic            e1AisDetectEn,
  output logic      [2:0] aisInstanceMask,
  output logic      [3:0] rdiPersistCount,
  output logic            aisToLopEnable,
  output logic            irqPin,
  output logic            v4AccessEnable,
  output logic            bip2TestDisable,
  // Clear and reset strobes, level while busy.
  output logic            globalClearBusy,
  output logic            aAddHizEnable,
  output logic            bAddHizEnable,
  output logic            aSideAlarmClear,
  output logic            bSideAlarmClear,
  output logic            processorRestart,
  output logic            processorRamInit
);

  // This block keeps the shared provisioning bits of the four ports and
  // runs the self-clearing commands. Each command is a down counter whose
  // nonzero value is both the read-back bit and the strobe to the ports.
  // The derived controls are registered, so every output settles one edge
  // after the stored field that feeds it; a write therefore shows on the
  // outputs two edges after the strobe. Context inputs come from logic on
  // the same clock and are used as they arrive, with no synchroniser.

  // Stored provisioning fields.
  logic [4:0] prov_q;       // Provisioning register, low five bits.
  logic       v4En_q;       // V4 access enable.
  logic       b2Dis_q;      // BIP-2 test disable.
  logic       hizA_q;       // A add-bus high-impedance enable.
  logic       hizB_q;       // B add-bus high-impedance enable.

  // Busy counters for the self-clearing commands. Each one is loaded with
  // its cycle length when its command bit is written and then counts down
  // to zero; a nonzero count means that command is still in progress.
  // Sixteen bits leave room for a long RAM init without a width change.
  logic [15:0] gclrCnt_q;   // Global clear cycles left.
  logic [15:0] aclrCnt_q;   // A-side alarm clear cycles left.
  logic [15:0] bclrCnt_q;   // B-side alarm clear cycles left.
  logic [15:0] prstCnt_q;   // Processor restart cycles left.
  logic [15:0] riniCnt_q;   // Processor RAM init cycles left.

  // Write decodes. A write strobe counts for exactly one clock edge, so
  // each decode is a plain combination of the strobe and the offset.
  logic wrProv;     // Write to the provisioning register.
  logic wrClear;    // Write to the command register.
  logic wrV4;       // Write to the V4 access register.
  logic wrBip2;     // Write to the BIP-2 test register.

  // Busy flags, one per self-clearing command. The read-back and the
  // strobe outputs both come from these, so software polling a command
  // bit and the logic watching its strobe see the same cycle.
  logic gclrBusy;   // Global clear running.
  logic aclrBusy;   // A-side alarm clear running.
  logic bclrBusy;   // B-side alarm clear running.
  logic prstBusy;   // Processor restart running.
  logic riniBusy;   // Processor RAM init running.

  // Decode of the four mapped offsets; any other offset is ignored.
  assign wrProv   = regWrite && (regAddr == ADDR_PROV);
  assign wrClear  = regWrite && (regAddr == ADDR_CLEAR);
  assign wrV4     = regWrite && (regAddr == ADDR_V4);
  assign wrBip2   = regWrite && (regAddr == ADDR_BIP2);

  // A command is busy exactly while its counter is nonzero.
  assign gclrBusy = (gclrCnt_q != 16'h0000);
  assign aclrBusy = (aclrCnt_q != 16'h0000);
  assign bclrBusy = (bclrCnt_q != 16'h0000);
  assign prstBusy = (prstCnt_q != 16'h0000);
  assign riniBusy = (riniCnt_q != 16'h0000);

  // Provisioning storage; the global clear zeroes prov_q, v4En_q and b2Dis_q. Unused
  // bits are masked so a careless write cannot wake them up.
  // Writes that land while the global clear runs are dropped on purpose:
  // letting them through would leave a half-cleared state behind, and
  // software is expected to poll the command bit before provisioning.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prov_q  <= 5'h00;
      v4En_q  <= 1'b0;
      b2Dis_q <= 1'b0;
    end else if (gclrBusy) begin
      prov_q  <= 5'h00;
      v4En_q  <= 1'b0;
      b2Dis_q <= 1'b0;
    end else begin
      if (wrProv) begin
        prov_q <= regWrData[4:0] & MASK_PROV[4:0];
      end
      if (wrV4) begin
        v4En_q <= regWrData[V4EN_BIT];
      end
      if (wrBip2) begin
        b2Dis_q <= regWrData[B2DIS_BIT];
      end
    end
  end

  // Add-bus high-impedance enables are forced to 1 by the global clear.
  // They also come up at 1 so the buses float until provisioned.
  // Their write path lives in another register, so this block only ever
  // sets them; it never drives them low on its own.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hizA_q <= 1'b1;
      hizB_q <= 1'b1;
    end else if (gclrBusy) begin
      hizA_q <= 1'b1;
      hizB_q <= 1'b1;
    end
  end

  // Global clear counter. A new command is ignored while one runs.
  // Restarting the count from a second write would stretch the clear
  // without limit if software kept writing, so the first one wins.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      gclrCnt_q <= 16'h0000;
    end else if (gclrBusy) begin
      gclrCnt_q <= gclrCnt_q - 16'h0001;
    end else if (wrClear && regWrData[GCLR_BIT]) begin
      gclrCnt_q <= 16'(GCLR_CYCLES);
    end
  end

  // A and B clears run independently, so both may start together.
  // They share one cycle length; a single write of both bits therefore
  // starts and ends both strobes on the same edges.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aclrCnt_q <= 16'h0000;
      bclrCnt_q <= 16'h0000;
    end else begin
      if (aclrCnt_q != 16'h0000) begin
        aclrCnt_q <= aclrCnt_q - 16'h0001;
      end else if (wrClear && regWrData[ACLR_BIT]) begin
        aclrCnt_q <= 16'(ACLR_CYCLES);
      end
      if (bclrCnt_q != 16'h0000) begin
        bclrCnt_q <= bclrCnt_q - 16'h0001;
      end else if (wrClear && regWrData[BCLR_BIT]) begin
        bclrCnt_q <= 16'(ACLR_CYCLES);
      end
    end
  end

  // Processor restart and RAM init. Software keeps them apart from the
  // global clear; hardware does not arbitrate beyond ignoring restarts.
  // A limitation: if both bits arrive in one write, both counters start,
  // and the processor sees restart and RAM init overlap.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prstCnt_q <= 16'h0000;
      riniCnt_q <= 16'h0000;
    end else begin
      if (prstCnt_q != 16'h0000) begin
        prstCnt_q <= prstCnt_q - 16'h0001;
      end else if (wrClear && regWrData[PRST_BIT]) begin
        prstCnt_q <= 16'(PRST_CYCLES);
      end
      if (riniCnt_q != 16'h0000) begin
        riniCnt_q <= riniCnt_q - 16'h0001;
      end else if (wrClear && regWrData[RINI_BIT]) begin
        riniCnt_q <= 16'(RINI_CYCLES);
      end
    end
  end

  // Registered outputs derived from provisioning and context.
  // Registering them costs one cycle of latency but keeps every port
  // control glitch-free while the context inputs change.
  // The reset values match a fully cleared provisioning register, except unequippedOnA and unequippedOnB, which both reset to 0.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      unequippedOnA   <= 1'b0;
      unequippedOnB   <= 1'b0;
      ptrAisDetectEn  <= 1'b1;
      e1AisDetectEn   <= 1'b0;
      aisInstanceMask <= 3'h1;
      rdiPersistCount <= RDI_SHORT;
      aisToLopEnable  <= 1'b0;
      irqPin          <= 1'b0;
      v4AccessEnable  <= 1'b0;
      bip2TestDisable <= 1'b0;
    end else begin
      // Multiplexer mode with the active-line enable clear: the channel
      // goes out on the bus that the drop direction names.
      if (busMode == MODE_MUX && !prov_q[UEAL_BIT]) begin
        unequippedOnA <= dropFromA;
        unequippedOnB <= !dropFromA;
      end else begin
        // Ring modes, or the enable set: the active bus carries it.
        unequippedOnA <= !activeBusB;
        unequippedOnB <= activeBusB;
      end
      ptrAisDetectEn  <= !prov_q[AISSEL_BIT];
      e1AisDetectEn   <= prov_q[AISSEL_BIT];
      aisInstanceMask <= au3Framing ? 3'h7 : 3'h1;
      rdiPersistCount <= prov_q[RDISEL_BIT] ? RDI_LONG : RDI_SHORT;
      aisToLopEnable  <= prov_q[A2L_BIT];
      irqPin          <= irqCondition && prov_q[HWIE_BIT];
      v4AccessEnable  <= v4En_q;
      bip2TestDisable <= b2Dis_q;
    end
  end

  // Command strobes, held high while each cycle runs.
  // Each strobe is the registered busy flag, so it rises one edge after
  // its counter is loaded and falls one edge after the counter reaches zero.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      globalClearBusy  <= 1'b0;
      aSideAlarmClear  <= 1'b0;
      bSideAlarmClear  <= 1'b0;
      processorRestart <= 1'b0;
      processorRamInit <= 1'b0;
      aAddHizEnable    <= 1'b1;
      bAddHizEnable    <= 1'b1;
    end else begin
      globalClearBusy  <= gclrBusy;
      aSideAlarmClear  <= aclrBusy;
      bSideAlarmClear  <= bclrBusy;
      processorRestart <= prstBusy;
      processorRamInit <= riniBusy;
      aAddHizEnable    <= hizA_q;
      bAddHizEnable    <= hizB_q;
    end
  end

  // Read data, registered; command bits show busy state.
  // The value holds between reads, so a slow host may take it late.
  // Unused and unmapped positions always read as zero.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      regRdData <= RST_REG;
    end else if (regRead) begin
      case (regAddr)
        ADDR_PROV:  regRdData <= {3'h0, prov_q};
        ADDR_CLEAR: regRdData <= {gclrBusy, aclrBusy,
                                  bclrBusy,
                                  prstBusy, 3'h0,
                                  riniBusy};
        ADDR_V4:    regRdData <= {4'h0, v4En_q, 3'h0};
        ADDR_BIP2:  regRdData <= {b2Dis_q, 7'h00};
        // Any other offset reads as zero.
        default:    regRdData <= 8'h00;
      endcase
    end
  end

endmodule

// ---- test/e1_map_common_asserts.sv ----
module e1_map_common_asserts
  import e1_map_common_pkg::*;
#(
  parameter int GCLR_CYCLES = CYC_GCLR,
  parameter int ACLR_CYCLES = CYC_ACLR,
  parameter int PRST_CYCLES = CYC_PRST,
  parameter int RINI_CYCLES = CYC_RINI
) (
  // Clock and reset.
  input wire logic       clock,
  input wire logic       resetn,
  // Register port.
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdData,
  // Context and derived controls.
  input wire logic [1:0] busMode,
  input wire logic       activeBusB,
  input wire logic       unequippedOnA,
  input wire logic       unequippedOnB,
  input wire logic       ptrAisDetectEn,
  input wire logic       e1AisDetectEn,
  input wire logic [3:0] rdiPersistCount,
  input wire logic       irqPin,
  input wire logic       bip2TestDisable,
  // Command strobes.
  input wire logic       globalClearBusy,
  input wire logic       aAddHizEnable,
  input wire logic       aSideAlarmClear,
  input wire logic       bSideAlarmClear
);
  // A running global clear swallows writes, so those are not judged.
  logic wrOk;
  assign wrOk = regWrite && !globalClearBusy;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  AST_AIS_SRC: assert property (
    ptrAisDetectEn != e1AisDetectEn
  ) else $error("AIS sources not exclusive");
  AST_RDI_CNT: assert property (
    wrOk && regAddr == ADDR_PROV |-> ##2 rdiPersistCount ==
    ($past(regWrData[RDISEL_BIT], 2) ? RDI_LONG : RDI_SHORT)
  ) else $error("RDI count wrong");
  AST_IRQ_OFF: assert property (
    wrOk && regAddr == ADDR_PROV && !regWrData[HWIE_BIT] |-> ##2 !irqPin
  ) else $error("interrupt pin active while disabled");
  AST_RING_ACT: assert property (
    busMode != MODE_MUX |=> unequippedOnB == $past(activeBusB)
    && unequippedOnA != $past(activeBusB)
  ) else $error("ring mode not on active bus");
  AST_ACLR_LEN: assert property (
    $rose(aSideAlarmClear) |-> aSideAlarmClear [*4] ##1 !aSideAlarmClear
  ) else $error("A clear length wrong");
  AST_AB_BOTH: assert property (
    wrOk && regAddr == ADDR_CLEAR && regWrData[ACLR_BIT]
    && regWrData[BCLR_BIT] && !aSideAlarmClear && !bSideAlarmClear
    |-> ##2 aSideAlarmClear && bSideAlarmClear
  ) else $error("joint clear not started");
  AST_BUSY_RD: assert property (
    regRead && regAddr == ADDR_CLEAR
    |=> regRdData[ACLR_BIT] == aSideAlarmClear
  ) else $error("busy command bit read as 0");
  AST_BIP2: assert property (
    wrOk && regAddr == ADDR_BIP2 |-> ##2
    bip2TestDisable == $past(regWrData[B2DIS_BIT], 2)
  ) else $error("BIP-2 disable not applied");
  AST_HIZ: assert property (
    $fell(globalClearBusy) |-> aAddHizEnable
  ) else $error("add bus not high impedance after clear");
endmodule

bind e1_mapper_common_provisioning e1_map_common_asserts #(
  .GCLR_CYCLES(GCLR_CYCLES),
  .ACLR_CYCLES(ACLR_CYCLES),
  .PRST_CYCLES(PRST_CYCLES),
  .RINI_CYCLES(RINI_CYCLES)
) chk (.*);

// ---- test/testbench.sv ----
module testbench
  import e1_map_common_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Register port, context and everything the block drives back.
  logic        clock, resetn, regWrite, regRead;
  logic [7:0]  regAddr, regWrData, regRdData;
  logic [1:0]  busMode;
  logic        dropFromA, activeBusB, au3Framing, irqCondition;
  logic        unequippedOnA, unequippedOnB, ptrAisDetectEn, e1AisDetectEn;
  logic [2:0]  aisInstanceMask;
  logic [3:0]  rdiPersistCount;
  logic        aisToLopEnable, irqPin, v4AccessEnable, bip2TestDisable;
  logic        globalClearBusy, aAddHizEnable, bAddHizEnable;
  logic        aSideAlarmClear, bSideAlarmClear;
  logic        processorRestart, processorRamInit;
  logic [3:0]  cmd;
  logic [15:0] got;
  int          n_mismatch, n_checks;
  // A row: written byte and context, then the expected derived outputs.
  typedef struct packed {
    logic [13:0] i;
    logic [12:0] o;
  } row_t;
  row_t        rows [5];
  assign cmd = {globalClearBusy, aSideAlarmClear,
                processorRestart, processorRamInit};
  // A short RAM init count keeps the run brief.
  e1_mapper_common_provisioning #(.RINI_CYCLES(4)) dut (.*);
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
      n_mismatch++;
    end
  endtask
  // Each strobe stands for exactly one clock edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    regWrite = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge clock);
    regWrite = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock);
    regRead = 1'b1;
    regAddr = a;
    @(negedge clock);
    regRead = 1'b0;
    @(negedge clock);
    chk(regRdData, e);
  endtask
  // Bounded wait for a command strobe to reach a level.
  task automatic wt(input int b, input logic v);
    for (int k = 0; k < 60; k++) begin
      @(negedge clock);
      if (cmd[b] === v) begin
        n_checks++;
        return;
      end
    end
    $display("[FAIL] %0t got %h exp %h", $time, cmd[b], v);
    n_mismatch++;
    close_out();
  endtask
  initial begin
    {resetn, regWrite, regRead, dropFromA, activeBusB} = '0;
    {au3Framing, irqCondition, regAddr, regWrData, busMode} = '0;
    rows = '{{{8'h00, 2'h0, 4'h9}, {4'hA, 3'h1, 4'h5, 2'h0}},
             {{8'h1F, 2'h0, 4'h3}, {4'h9, 3'h7, 4'hA, 2'h3}},
             {{8'h03, 2'h0, 4'h5}, {4'h6, 3'h1, 4'h5, 2'h3}},
             {{8'h10, 2'h1, 4'hE}, {4'h6, 3'h7, 4'h5, 2'h0}},
             {{8'h04, 2'h2, 4'h1}, {4'hA, 3'h1, 4'hA, 2'h0}}};
    repeat (12) @(negedge clock);
    resetn = 1'b1;
    foreach (rows[k]) begin
      {busMode, dropFromA, activeBusB, au3Framing, irqCondition} = rows[k].i;
      wr(ADDR_PROV, rows[k].i[13:6]);
      repeat (2) @(negedge clock);
      got = {unequippedOnA, unequippedOnB, ptrAisDetectEn, e1AisDetectEn,
             aisInstanceMask, rdiPersistCount, aisToLopEnable, irqPin};
      chk(got, rows[k].o);
      rd(ADDR_PROV, rows[k].i[13:6]);
    end
    $display("test table done");
    // A reset in mid-run must bring back the idle settings.
    busMode = MODE_MUX;
    resetn = 1'b0;
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    got = {ptrAisDetectEn, aisInstanceMask, rdiPersistCount,
           aAddHizEnable, bAddHizEnable};
    chk(got, 16'h0257);
    rd(ADDR_CLEAR, 8'h00);
    $display("test reset done");
    wr(ADDR_V4, 8'h08);
    wr(ADDR_BIP2, 8'h80);
    repeat (2) @(negedge clock);
    chk({v4AccessEnable, bip2TestDisable}, 16'h0003);
    rd(ADDR_V4, 8'h08);
    wr(8'h16, 8'hFF);
    rd(8'h16, 8'h00);
    $display("test v4 bip2 done");
    wr(ADDR_CLEAR, 8'h60);
    rd(ADDR_CLEAR, 8'h60);
    chk({aSideAlarmClear, bSideAlarmClear}, 16'h0003);
    rd(ADDR_CLEAR, 8'h00);
    wt(2, 1'b0);
    rd(ADDR_CLEAR, 8'h00);
    $display("test side clears done");
    wr(ADDR_CLEAR, 8'h80);
    rd(ADDR_CLEAR, 8'h80);
    wt(3, 1'b0);
    got = {v4AccessEnable, bip2TestDisable, aAddHizEnable,
           bAddHizEnable, rdiPersistCount};
    chk(got, 16'h0035);
    rd(ADDR_BIP2, 8'h00);
    wr(ADDR_CLEAR, 8'h10);
    wt(1, 1'b1);
    wt(1, 1'b0);
    wr(ADDR_CLEAR, 8'h01);
    wt(0, 1'b1);
    wt(0, 1'b0);
    $display("test commands done");
    close_out();
  end
endmodule
